/* hw/amp_sysctl_irq_i2s_config.sv */
/*
 * Control and status register group of the amplifier: event flags with
 * read-clear, masks, interrupt pin, system control and serial audio format.
 * Assumes a host on the two-wire control bus and status levels that are
 * already synchronous to core_clk.
 */
// Functional notes
// - Live status change sets flag; read clears
// - Power-on also sets under-voltage flag
// - Mask bit one hides source; reset masked
// - Pin config bit0 picks flags or live
// - Pin config bit1: open-drain or push-pull
// - Control bit7 picks speaker or earpiece
// - Control bit6 enables serial audio path
// - Control bit5 swaps left and right
// - Control bit4 inverts received bit clock
// - Control bit3 picks PLL reference signal
// - Control bit1 holds amplifier off; reset one
// - Control bit0 drives system off, forces amp off; reset one
// - Attenuate bit halves incoming audio
// - Channel pick: left, right, mono average
// - Frame format code: standard, MSB, LSB
// - Word width code 16/20/24/32, reset 32
// - Bit clock ratio 32/48/64, reset 64
// - Rate code; 11 to 15 mean 48k
// - Live status tracks current conditions
`timescale 1ns/1ps
module amp_sysctl_irq_i2s_config import amp_pkg::*; (
   // Clock and reset
   input wire logic core_clk,
   input wire logic nrst,
   // Control bus pins
   input wire logic scl_in,
   input wire logic sda_in,
   output logic sda_out,
   output logic sda_oe,
   // Live status levels
   input wire logic [15:0] status_live,
   // Interrupt pin
   output logic irq_out_n,
   output logic irq_oe,
   // System control
   output logic earpiece_select,
   output logic serial_audio_on,
   output logic lr_swap,
   output logic bitclk_polarity,
   output logic pll_ref_select,
   output logic amp_off,
   output logic system_off,
   // Serial audio clocks
   input wire logic bclk_in,
   input wire logic ws_in,
   output logic bclk_used,
   output logic pll_ref_clk,
   // Serial audio format
   output logic input_attenuate,
   output logic [1:0] channel_pick,
   output logic [1:0] frame_format,
   output logic [1:0] word_width,
   output logic [1:0] bitclk_ratio,
   output logic [3:0] sample_rate_code,
   // Sample path
   input wire logic pair_valid,
   input wire logic [31:0] left_in,
   input wire logic [31:0] right_in,
   output logic sample_valid,
   output logic [31:0] sample_out
);
   // ************************************************************
   // Helpers
   // ************************************************************
   function automatic logic [15:0] merge(input logic [15:0] old, input logic [15:0] val,
                                         input logic [15:0] wmask);
      merge = (old & ~wmask) | (val & wmask);
   endfunction

   function automatic logic [3:0] rate_fold(input logic [3:0] code);
      rate_fold = (code >= RATE_ALIAS_FIRST) ? RATE_48K : code;
   endfunction

   // ************************************************************
   // State
   // ************************************************************
   typedef struct packed {
      logic [15:0] flags;
      logic [15:0] masks;
      logic [15:0] ctrl;
      logic [15:0] fmt;
      logic [15:0] live_q;
      logic primed;
      logic first;
      logic irq_n;
      logic irq_oe;
      logic sda_level;
      logic amp_hold;
      logic bclk_used;
      logic pll_ref;
      logic [3:0] rate;
   } regs_s;

   regs_s r;
   regs_s next_r;
   logic bus_wr, bus_rd;
   logic [7:0] bus_addr;
   logic [15:0] bus_wdata, bus_rdata, chg, clr, pending;
   logic assert_irq;

   // ************************************************************
   // Bus engine and sample path
   // ************************************************************
   i2c_target u_bus (
      .core_clk(core_clk),
      .nrst(nrst),
      .scl_in(scl_in),
      .sda_in(sda_in),
      .sda_oe(sda_oe),
      .wr(bus_wr),
      .rd(bus_rd),
      .addr(bus_addr),
      .wdata(bus_wdata),
      .rdata(bus_rdata)
   );

   audio_select u_path (
      .core_clk(core_clk),
      .nrst(nrst),
      .en(r.ctrl[SER_ON_BIT]),
      .swap(r.ctrl[SWAP_BIT]),
      .atten(r.fmt[ATTEN_BIT]),
      .pick(r.fmt[PICK_LSB +: 2]),
      .in_valid(pair_valid),
      .left(left_in),
      .right(right_in),
      .out_valid(sample_valid),
      .sample(sample_out)
   );

   // ************************************************************
   // Outputs
   // ************************************************************
   assign sda_out = r.sda_level;
   assign irq_out_n = r.irq_n;
   assign irq_oe = r.irq_oe;
   assign earpiece_select = r.ctrl[EAR_BIT];
   assign serial_audio_on = r.ctrl[SER_ON_BIT];
   assign lr_swap = r.ctrl[SWAP_BIT];
   assign bitclk_polarity = r.ctrl[BCLK_INV_BIT];
   assign pll_ref_select = r.ctrl[PLL_REF_BIT];
   assign amp_off = r.amp_hold;
   assign system_off = r.ctrl[SYS_OFF_BIT];
   assign bclk_used = r.bclk_used;
   assign pll_ref_clk = r.pll_ref;
   assign input_attenuate = r.fmt[ATTEN_BIT];
   assign channel_pick = r.fmt[PICK_LSB +: 2];
   assign frame_format = r.fmt[FMT_LSB +: 2];
   assign word_width = r.fmt[WIDTH_LSB +: 2];
   assign bitclk_ratio = r.fmt[RATIO_LSB +: 2];
   assign sample_rate_code = r.rate;

   // ************************************************************
   // Read mux
   // ************************************************************
   always_comb begin
      case (bus_addr)
         OFS_STATUS: bus_rdata = status_live & FLAG_BITS;
         OFS_FLAGS: bus_rdata = r.flags;
         OFS_MASKS: bus_rdata = r.masks;
         OFS_CTRL: bus_rdata = r.ctrl;
         OFS_FMT: bus_rdata = r.fmt;
         default: bus_rdata = 16'h0000;
      endcase
   end

   // ************************************************************
   // Next state
   // ************************************************************
   always_comb begin
      next_r = r;
      next_r.first = 1'b0;
      next_r.primed = 1'b1;
      next_r.live_q = status_live;
      // First cycle only primes the history, so power-up levels are no event
      chg = r.primed ? (status_live ^ r.live_q) & FLAG_BITS : 16'h0000;
      clr = (bus_rd && bus_addr == OFS_FLAGS) ? FLAG_BITS : 16'h0000;
      // A change landing on the clearing read survives it
      next_r.flags = (r.flags & ~clr) | chg;
      if (bus_wr) begin
         case (bus_addr)
            OFS_MASKS: next_r.masks = merge(r.masks, bus_wdata, MASK_WR);
            OFS_CTRL: next_r.ctrl = merge(r.ctrl, bus_wdata, CTRL_WR);
            OFS_FMT: next_r.fmt = merge(r.fmt, bus_wdata, FMT_WR);
            default: next_r.fmt = r.fmt;
         endcase
      end
      if (r.ctrl[IRQ_SRC_BIT]) begin
         pending = status_live & ~r.masks & FLAG_BITS;
      end else begin
         pending = r.flags & ~r.masks & FLAG_BITS;
      end
      assert_irq = |pending;
      next_r.irq_n = !assert_irq;
      next_r.irq_oe = r.ctrl[IRQ_PP_BIT] || assert_irq;
      next_r.amp_hold = next_r.ctrl[AMP_OFF_BIT] || next_r.ctrl[SYS_OFF_BIT];
      next_r.bclk_used = bclk_in ^ r.ctrl[BCLK_INV_BIT];
      next_r.pll_ref = r.ctrl[PLL_REF_BIT] ? ws_in : bclk_in;
      next_r.rate = rate_fold(next_r.fmt[RATE_LSB +: 4]);
   end

   always_ff @(posedge core_clk or negedge nrst) begin
      if (!nrst) begin
         r <= '{flags: FLAG_RST, masks: MASK_RST, ctrl: CTRL_RST, fmt: FMT_RST,
                rate: RATE_48K, first: 1'b1, irq_n: 1'b1, amp_hold: 1'b1, default: '0};
      end else begin
         r <= next_r;
      end
   end

   // ************************************************************
   // Checks
   // ************************************************************
   default clocking @(posedge core_clk); endclocking
   default disable iff (!nrst);

   a_change_sets: assert property ((chg != 16'h0000) |=> (r.flags & $past(chg)) == $past(chg))
      else $error("status change did not set its flag");
   a_read_clears: assert property (bus_rd && bus_addr == OFS_FLAGS && chg == 16'h0000
      |=> r.flags == 16'h0000)
      else $error("flag read did not clear");
   a_power_on_uv: assert property (r.first |-> r.flags[UV_BIT] && r.masks == MASK_RST)
      else $error("power-on flag or mask reset wrong");
   a_all_masked: assert property ((r.masks & FLAG_BITS) == FLAG_BITS |=> irq_out_n)
      else $error("masked source reached the pin");
   a_latched_irq: assert property (!r.ctrl[IRQ_SRC_BIT] && (r.flags & ~r.masks & FLAG_BITS) != 0
      |=> !irq_out_n && irq_oe)
      else $error("unmasked flag did not pull the pin");
   a_live_irq: assert property (r.ctrl[IRQ_SRC_BIT] && (status_live & ~r.masks & FLAG_BITS) != 0
      |=> !irq_out_n)
      else $error("live source did not drive the pin");
   a_drive_type: assert property (!r.ctrl[IRQ_PP_BIT] && irq_out_n ##1 !r.ctrl[IRQ_PP_BIT]
      |-> irq_oe == !irq_out_n)
      else $error("open-drain pin driven high");
   a_ctrl_reset: assert property (r.first |-> system_off && amp_off && !serial_audio_on
      && !earpiece_select)
      else $error("control reset values wrong");
   a_fmt_reset: assert property (r.first |-> word_width == 2'h3 && bitclk_ratio == 2'h2
      && channel_pick == PICK_LEFT && sample_rate_code == RATE_48K)
      else $error("format reset values wrong");
   a_rate_alias: assert property (r.fmt[RATE_LSB +: 4] >= RATE_ALIAS_FIRST |-> r.rate == RATE_48K)
      else $error("high rate codes not folded");
   a_sys_off_amp: assert property (r.ctrl[SYS_OFF_BIT] |-> amp_off)
      else $error("amplifier active while system off");

   c_irq_pull: cover property (!irq_out_n ##1 irq_out_n);
   c_read_clear: cover property (bus_rd && bus_addr == OFS_FLAGS && r.flags != 16'h0000);
   c_ctrl_write: cover property (bus_wr && bus_addr == OFS_CTRL);
endmodule

/* hw/amp_pkg.sv */
/*
 * Shared constants for the amplifier control register group: register
 * offsets, field positions, reset values, write masks, codes and the
 * control-bus engine states.
 * Assumes a 16-bit register word reached by an 8-bit register pointer.
 */
package amp_pkg;
   // ************************************************************
   // Register offsets
   // ************************************************************
   localparam logic [7:0] OFS_STATUS = 8'h01;
   localparam logic [7:0] OFS_FLAGS = 8'h02;
   localparam logic [7:0] OFS_MASKS = 8'h03;
   localparam logic [7:0] OFS_CTRL = 8'h04;
   localparam logic [7:0] OFS_FMT = 8'h05;

   // Control-bus target address (arbitrary value)
   localparam logic [6:0] DEV_ADDR = 7'h2a;

   // ************************************************************
   // Field positions
   // ************************************************************
   localparam int UV_BIT = 14;
   localparam int IRQ_SRC_BIT = 8;
   localparam int IRQ_PP_BIT = 9;
   localparam int EAR_BIT = 7;
   localparam int SER_ON_BIT = 6;
   localparam int SWAP_BIT = 5;
   localparam int BCLK_INV_BIT = 4;
   localparam int PLL_REF_BIT = 3;
   localparam int AMP_OFF_BIT = 1;
   localparam int SYS_OFF_BIT = 0;
   localparam int ATTEN_BIT = 13;
   localparam int PICK_LSB = 10;
   localparam int FMT_LSB = 8;
   localparam int WIDTH_LSB = 6;
   localparam int RATIO_LSB = 4;
   localparam int RATE_LSB = 0;

   // ************************************************************
   // Reset values and writable bits
   // ************************************************************
   localparam logic [15:0] FLAG_BITS = 16'h6fbf;
   localparam logic [15:0] FLAG_RST = 16'h4000;
   localparam logic [15:0] MASK_RST = 16'h7fff;
   localparam logic [15:0] MASK_WR = 16'hefbf;
   localparam logic [15:0] CTRL_RST = 16'h0007;
   localparam logic [15:0] CTRL_WR = 16'h03fb;
   localparam logic [15:0] FMT_RST = 16'h04e8;
   localparam logic [15:0] FMT_WR = 16'h2fff;

   // ************************************************************
   // Codes
   // ************************************************************
   localparam logic [1:0] PICK_LEFT = 2'h1;
   localparam logic [1:0] PICK_RIGHT = 2'h2;
   localparam logic [1:0] PICK_MONO = 2'h3;
   localparam logic [3:0] RATE_48K = 4'h8;
   localparam logic [3:0] RATE_ALIAS_FIRST = 4'hb;

   typedef enum logic [7:0] {
      ST_IDLE = 8'h01,
      ST_DEV = 8'h02,
      ST_REG = 8'h04,
      ST_WR = 8'h08,
      ST_ACK = 8'h10,
      ST_LOAD = 8'h20,
      ST_RD = 8'h40,
      ST_MACK = 8'h80
   } i2c_state_e;
endpackage

/* hw/i2c_target.sv */
/*
 * Control-bus target: 7-bit address, 8-bit register pointer, 16-bit words
 * sent high byte first, pointer advancing after every written word and every acknowledged read word.
 * Assumes SCL and SDA are already synchronous to core_clk.
 */
`timescale 1ns/1ps
module i2c_target import amp_pkg::*; (
   // Clock and reset
   input wire logic core_clk,
   input wire logic nrst,
   // Bus pins
   input wire logic scl_in,
   input wire logic sda_in,
   output logic sda_oe,
   // Register side
   output logic wr,
   output logic rd,
   output logic [7:0] addr,
   output logic [15:0] wdata,
   input wire logic [15:0] rdata
);
   typedef struct packed {
      i2c_state_e st;
      i2c_state_e after;
      logic [3:0] cnt;
      logic [7:0] sh;
      logic [7:0] hold;
      logic [15:0] word;
      logic [15:0] wdata;
      logic [7:0] ptr;
      logic hi;
      logic nack;
      logic scl_q;
      logic sda_q;
      logic sda_oe;
      logic wr;
   } i2c_s;

   i2c_s r;
   i2c_s next_r;
   logic rise, fall, start, stop;
   logic [7:0] byte_out;

   assign sda_oe = r.sda_oe;
   assign wr = r.wr;
   assign addr = r.ptr;
   assign wdata = r.wdata;
   // Fetch is taken the same edge the word is captured, so a read-clear
   // never loses an event that arrives between capture and clear
   assign rd = (r.st == ST_LOAD) && !r.hi;

   always_comb begin
      next_r = r;
      next_r.wr = 1'b0;
      next_r.scl_q = scl_in;
      next_r.sda_q = sda_in;
      rise = !r.scl_q && scl_in;
      fall = r.scl_q && !scl_in;
      start = r.scl_q && scl_in && r.sda_q && !sda_in;
      stop = r.scl_q && scl_in && !r.sda_q && sda_in;
      byte_out = r.hi ? r.word[7:0] : rdata[15:8];
      if (r.wr) begin
         next_r.ptr = r.ptr + 8'h01;
      end
      if (start) begin
         next_r.st = ST_DEV;
         next_r.cnt = 4'h0;
         next_r.sda_oe = 1'b0;
      end else if (stop) begin
         next_r.st = ST_IDLE;
         next_r.sda_oe = 1'b0;
      end else begin
         case (r.st)
            ST_IDLE: begin
               next_r.sda_oe = 1'b0;
            end
            ST_DEV, ST_REG, ST_WR: begin
               if (rise) begin
                  next_r.sh = {r.sh[6:0], sda_in};
                  next_r.cnt = r.cnt + 4'h1;
               end else if (fall && r.cnt == 4'h8) begin
                  next_r.cnt = 4'h0;
                  next_r.st = ST_ACK;
                  next_r.sda_oe = 1'b1;
                  next_r.after = ST_WR;
                  if (r.st == ST_DEV) begin
                     next_r.hi = 1'b0;
                     next_r.after = r.sh[0] ? ST_LOAD : ST_REG;
                     if (r.sh[7:1] != DEV_ADDR) begin
                        next_r.st = ST_IDLE;
                        next_r.sda_oe = 1'b0;
                     end
                  end else if (r.st == ST_REG) begin
                     next_r.ptr = r.sh;
                     next_r.hi = 1'b0;
                  end else if (!r.hi) begin
                     next_r.hold = r.sh;
                     next_r.hi = 1'b1;
                  end else begin
                     next_r.wr = 1'b1;
                     next_r.wdata = {r.hold, r.sh};
                     next_r.hi = 1'b0;
                  end
               end
            end
            ST_ACK: begin
               if (fall) begin
                  next_r.sda_oe = 1'b0;
                  next_r.st = r.after;
               end
            end
            ST_LOAD: begin
               if (!r.hi) begin
                  next_r.word = rdata;
               end
               next_r.sda_oe = !byte_out[7];
               next_r.sh = {byte_out[6:0], 1'b0};
               next_r.cnt = 4'h1;
               next_r.st = ST_RD;
            end
            ST_RD: begin
               if (fall && r.cnt == 4'h8) begin
                  next_r.sda_oe = 1'b0;
                  next_r.cnt = 4'h0;
                  next_r.st = ST_MACK;
               end else if (fall) begin
                  next_r.sda_oe = !r.sh[7];
                  next_r.sh = {r.sh[6:0], 1'b0};
                  next_r.cnt = r.cnt + 4'h1;
               end
            end
            ST_MACK: begin
               if (rise) begin
                  next_r.nack = sda_in;
               end else if (fall && r.nack) begin
                  next_r.st = ST_IDLE;
               end else if (fall) begin
                  next_r.st = ST_LOAD;
                  next_r.hi = !r.hi;
                  if (r.hi) begin
                     next_r.ptr = r.ptr + 8'h01;
                  end
               end
            end
            default: begin
               next_r.st = ST_IDLE;
            end
         endcase
      end
   end

   always_ff @(posedge core_clk or negedge nrst) begin
      if (!nrst) begin
         r <= '{st: ST_IDLE, after: ST_IDLE, scl_q: 1'b1, sda_q: 1'b1, default: '0};
      end else begin
         r <= next_r;
      end
   end
endmodule

/* hw/audio_select.sv */
/*
 * Input sample path: channel swap, channel pick or mono average, and the
 * optional halving of the level. One registered stage.
 * Assumes left and right words arrive together with one valid pulse.
 */
`timescale 1ns/1ps
module audio_select import amp_pkg::*; (
   // Clock and reset
   input wire logic core_clk,
   input wire logic nrst,
   // Settings
   input wire logic en,
   input wire logic swap,
   input wire logic atten,
   input wire logic [1:0] pick,
   // Samples
   input wire logic in_valid,
   input wire logic [31:0] left,
   input wire logic [31:0] right,
   output logic out_valid,
   output logic [31:0] sample
);
   typedef struct packed {
      logic [31:0] smp;
      logic vld;
   } path_s;

   path_s r;
   path_s next_r;
   logic [31:0] a, b, s;
   logic [32:0] sum;

   assign out_valid = r.vld;
   assign sample = r.smp;

   always_comb begin
      next_r = r;
      a = swap ? right : left;
      b = swap ? left : right;
      sum = {a[31], a} + {b[31], b};
      case (pick)
         PICK_LEFT: s = a;
         PICK_RIGHT: s = b;
         PICK_MONO: s = sum[32:1];
         default: s = 32'h0000_0000;
      endcase
      if (atten) begin
         s = {s[31], s[31:1]};
      end
      next_r.vld = en && in_valid;
      if (!en) begin
         next_r.smp = 32'h0000_0000;
      end else if (in_valid) begin
         next_r.smp = s;
      end
   end

   always_ff @(posedge core_clk or negedge nrst) begin
      if (!nrst) begin
         r <= '0;
      end else begin
         r <= next_r;
      end
   end

   default clocking @(posedge core_clk); endclocking
   default disable iff (!nrst);

   a_off_silent: assert property (!en |=> !out_valid && sample == 32'h0000_0000)
      else $error("sample path active while disabled");
   a_left_plain: assert property (en && in_valid && pick == PICK_LEFT && !swap && !atten
      |=> sample == $past(left))
      else $error("left pick does not pass left word");
   a_atten_half: assert property (en && in_valid && pick == PICK_RIGHT && swap && atten
      |=> sample == {$past(left[31]), $past(left[31:1])})
      else $error("swapped halved word wrong");
   c_mono: cover property (en && in_valid && pick == PICK_MONO);
endmodule

/* sim/i2c_host.sv */
/* Host model on the two-wire control bus: word writes and word reads.
   Assumes a pull-up on SDA and a target that only ever pulls it low. */
`timescale 1ns/1ps
module i2c_host import amp_pkg::*; (
   // Clock
   input wire logic core_clk,
   // Bus
   input wire logic dut_oe,
   output logic scl,
   output logic sda_line
);
   logic drv = 1'b1;
   logic last_ack = 1'b1;
   int nacks = 0;
   initial scl = 1'b1;
   // Released line floats high
   assign sda_line = drv & ~dut_oe;
   task automatic tick(input int n);
      repeat (n) @(posedge core_clk);
      #1;
   endtask
   // ************************************************************
   // Bus cycles
   // ************************************************************
   // Five cycles low stays clear of the target's four-cycle minimum
   task automatic bit_io(input logic b, output logic r);
      scl = 1'b0;
      tick(2);
      drv = b;
      tick(3);
      scl = 1'b1;
      tick(3);
      r = sda_line;
      tick(2);
   endtask
   // Start when lvl is 0, stop when 1
   task automatic cond(input logic lvl);
      scl = 1'b0;
      tick(2);
      drv = ~lvl;
      tick(3);
      scl = 1'b1;
      tick(3);
      drv = lvl;
      tick(3);
   endtask
   task automatic xfer(input logic [7:0] d, input logic ack, output logic [7:0] q);
      for (int i = 7; i >= 0; i--) begin
         bit_io(d[i], q[i]);
      end
      bit_io(ack, last_ack);
   endtask
   task automatic put(input logic [7:0] d);
      logic [7:0] q;
      xfer(d, 1'b1, q);
      nacks += int'(last_ack);
   endtask
   // High byte first
   task automatic wr_reg(input logic [7:0] a, input logic [15:0] v);
      cond(1'b0);
      put({DEV_ADDR, 1'b0});
      put(a);
      put(v[15:8]);
      put(v[7:0]);
      cond(1'b1);
   endtask
   task automatic rd_reg(input logic [7:0] a, output logic [15:0] v);
      cond(1'b0);
      put({DEV_ADDR, 1'b0});
      put(a);
      cond(1'b0);
      put({DEV_ADDR, 1'b1});
      xfer(8'hff, 1'b0, v[15:8]);
      xfer(8'hff, 1'b1, v[7:0]);
      cond(1'b1);
   endtask
endmodule

/* sim/amp_sysctl_irq_i2s_config_test.sv */
/* Bench for the amplifier register group: host model on the control bus,
   random status levels, clocks and sample pairs.
   Assumes amp_pkg and i2c_host are compiled first. */
`timescale 1ns/1ps
module amp_sysctl_irq_i2s_config_test import amp_pkg::*;;
   logic core_clk = 1'b0;
   logic nrst = 1'b0;
   logic scl, sda, sda_oe, irq_out_n, irq_oe, bclk_used, pll_ref_clk, sample_valid, sda_out;
   logic bclk_in = 1'b0;
   logic ws_in = 1'b0;
   logic pair_valid = 1'b0;
   logic [15:0] status_live = 16'h0000;
   logic [15:0] rnd = 16'h001d;
   logic [15:0] old, w, rd_val;
   logic [31:0] left_in = 32'h0, right_in = 32'h0, sample_out, l, r;
   logic [6:0] ctl;
   logic [12:0] fo;
   logic [1:0] pk;
   logic [15:0] exp_reg[$];
   logic [31:0] exp_smp[$];
   int errors = 0;
   int n_tests = 0;
   event rd_ev;
   always #5 core_clk = ~core_clk;
   i2c_host u_host (.core_clk(core_clk), .dut_oe(sda_oe), .scl(scl), .sda_line(sda));
   amp_sysctl_irq_i2s_config u_dut (.core_clk(core_clk), .nrst(nrst), .scl_in(scl),
      .sda_in(sda), .sda_out(sda_out), .sda_oe(sda_oe), .status_live(status_live),
      .irq_out_n(irq_out_n), .irq_oe(irq_oe), .earpiece_select(ctl[6]),
      .serial_audio_on(ctl[5]), .lr_swap(ctl[4]), .bitclk_polarity(ctl[3]),
      .pll_ref_select(ctl[2]), .amp_off(ctl[1]), .system_off(ctl[0]), .bclk_in(bclk_in),
      .ws_in(ws_in), .bclk_used(bclk_used), .pll_ref_clk(pll_ref_clk),
      .input_attenuate(fo[12]), .channel_pick(fo[11:10]), .frame_format(fo[9:8]),
      .word_width(fo[7:6]), .bitclk_ratio(fo[5:4]), .sample_rate_code(fo[3:0]),
      .pair_valid(pair_valid), .left_in(left_in), .right_in(right_in),
      .sample_valid(sample_valid), .sample_out(sample_out));
   task automatic tick(input int n);
      repeat (n) @(posedge core_clk);
      #1;
   endtask
   task automatic check(input logic [31:0] got, input logic [31:0] exp);
      n_tests++;
      if (got !== exp) begin
         errors++;
         $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask
   task automatic print_verdict();
      if (errors == 0 && n_tests > 0) $display("[ PASS ]");
      else $display("[ FAIL ]");
      $finish;
   endtask
   task automatic check_reg(input logic [15:0] got, input logic [15:0] exp);
      check(32'(got), 32'(exp));
   endtask
   task automatic check_smp(input logic [31:0] got, input logic [31:0] exp);
      check(got, exp);
   endtask
   function automatic logic [15:0] lfsr(input logic [15:0] s);
      return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
   endfunction
   function automatic logic [31:0] model(input logic sw, input logic at,
      input logic [1:0] p, input logic signed [31:0] a0, input logic signed [31:0] b0);
      logic signed [31:0] a, b, m;
      a = sw ? b0 : a0;
      b = sw ? a0 : b0;
      m = (p == 2'h1) ? a : (p == 2'h2) ? b : (p == 2'h3) ? (a + b) >>> 1 : 32'sh0;
      return at ? m >>> 1 : m;
   endfunction
   task automatic rd_expect(input logic [7:0] a, input logic [15:0] e);
      exp_reg.push_back(e);
      u_host.rd_reg(a, rd_val);
      -> rd_ev;
   endtask
   task automatic send_pair(input logic on, input logic [31:0] e);
      if (on) exp_smp.push_back(e);
      left_in = l;
      right_in = r;
      pair_valid = 1'b1;
      tick(1);
      pair_valid = 1'b0;
      check(32'(sample_valid), 32'(on));
      tick(2);
   endtask
   // ************************************************************
   // Result watchers
   // ************************************************************
   always @(rd_ev) check_reg(rd_val, exp_reg.pop_front());
   always @(negedge core_clk) begin
      if (sample_valid === 1'b1) check_smp(sample_out, exp_smp.pop_front());
   end
   initial begin
      tick(60000);
      errors++;
      print_verdict();
   end
   initial begin
      tick(8);
      nrst = 1'b1;
      tick(2);
      check(32'({irq_out_n, irq_oe, ctl, fo}), 32'({9'h103, 13'h04e8}));
      rd_expect(OFS_FLAGS, FLAG_RST);
      rd_expect(OFS_FLAGS, 16'h0000);
      rd_expect(OFS_MASKS, MASK_RST);
      rd_expect(OFS_CTRL, CTRL_RST);
      rd_expect(OFS_FMT, FMT_RST);
      rd_expect(8'h07, 16'h0000);
      u_host.wr_reg(OFS_MASKS, 16'h0000);
      rd_expect(OFS_MASKS, 16'h1040);
      for (int i = 0; i < 4; i++) begin
         old = status_live;
         rnd = lfsr(rnd);
         status_live = rnd;
         tick(3);
         check(32'({irq_out_n, irq_oe}), ((old ^ rnd) & FLAG_BITS) != 0 ? 32'h1 : 32'h2);
         rd_expect(OFS_FLAGS, (old ^ rnd) & FLAG_BITS);
         check(32'({irq_out_n, irq_oe}), 32'h2);
      end
      u_host.wr_reg(OFS_MASKS, 16'hffff);
      status_live = ~status_live;
      tick(3);
      check(32'({irq_out_n, irq_oe}), 32'h2);
      rd_expect(OFS_FLAGS, FLAG_BITS);
      u_host.wr_reg(OFS_MASKS, 16'hff7f);
      u_host.wr_reg(OFS_CTRL, 16'h0307);
      for (int v = 0; v < 4; v++) begin
         status_live[7] = ~status_live[7];
         tick(3);
         check(32'({irq_out_n, irq_oe}), 32'({~status_live[7], 1'b1}));
      end
      u_host.wr_reg(OFS_CTRL, 16'h0207);
      check(32'({irq_out_n, irq_oe}), 32'h1);
      rd_expect(OFS_FLAGS, 16'h0080);
      check(32'({irq_out_n, irq_oe}), 32'h3);
      for (int b = 0; b < 8; b++) begin
         w = 16'h0001 << b;
         u_host.wr_reg(OFS_CTRL, w);
         bclk_in = rnd[0];
         ws_in = rnd[1];
         rnd = lfsr(rnd);
         tick(2);
         check(32'(ctl), 32'({w[7:3], w[1] | w[0], w[0]}));
         check(32'({bclk_used, pll_ref_clk}), 32'({bclk_in ^ w[4], w[3] ? ws_in : bclk_in}));
      end
      rd_expect(OFS_CTRL, 16'h0084);
      send_pair(1'b0, 32'h0);
      for (int i = 0; i < 16; i++) begin
         pk = 2'(i % 3 + 1);
         w = {2'b00, i[0], 1'b0, pk, 2'(i % 3), i[1:0], 2'(i % 3), i[3:0]};
         u_host.wr_reg(OFS_FMT, w);
         u_host.wr_reg(OFS_CTRL, {10'h001, i[1], 5'h00});
         check(32'(fo), 32'({w[13], w[11:4], i > 10 ? RATE_48K : w[3:0]}));
         rd_expect(OFS_FMT, w);
         rnd = lfsr(rnd);
         l = {{16{rnd[15]}}, rnd};
         rnd = lfsr(rnd);
         r = {{16{rnd[15]}}, rnd};
         send_pair(1'b1, model(i[1], i[0], pk, l, r));
      end
      u_host.wr_reg(OFS_FMT, 16'h0000);
      send_pair(1'b1, 32'h0);
      u_host.wr_reg(OFS_FLAGS, 16'hffff);
      rd_expect(OFS_FLAGS, 16'h0000);
      u_host.cond(1'b0);
      u_host.xfer({DEV_ADDR ^ 7'h01, 1'b0}, 1'b1, w[7:0]);
      u_host.cond(1'b1);
      check(32'({sda_out, u_host.last_ack}), 32'h1);
      check(u_host.nacks, 32'h0);
      nrst = 1'b0;
      tick(2);
      nrst = 1'b1;
      tick(2);
      rd_expect(OFS_FLAGS, FLAG_RST);
      // Let the read watcher take the last result before the verdict
      tick(1);
      print_verdict();
   end
endmodule
